// File: src/sumu_unit.sv
// dual, halfword, word-by-halfword and long multiply datapath
//
// Functional notes
// - dual add sums the two signed 16x16 halfword products into the destination.
// - crossed forms swap second operand halfwords before multiplying.
// - dual subtract writes bottom product minus top product.
// - saturation flag otherwise keeps its value; only a status write clears it.
// - halfword multiply takes first operand bits 15:0 or 31:16 as selected.
// - halfword and word forms pick bottom or top second operand halfword.
// - halfword multiply writes the full signed 32-bit product.
// - word-by-halfword writes the upper 32 bits of the 48-bit product.
// - unsigned long multiply splits the 64-bit product over low and high.
// - unsigned long accumulate adds the product to the 64-bit register pair.
// - double accumulate adds both 32-bit destination words to the product.
// - signed long multiply splits the signed 64-bit product over the pair.
// - signed long accumulate adds the product to the signed 64-bit pair.
// - long forms leave the negative, zero, carry, overflow flags unchanged.
`timescale 1ns/1ns
module sumu_unit (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // issue from the decoder
    input wire logic issue_valid_in,
    input wire sumu_pkg::sumu_op_type op_in,
    input wire logic [31:0] first_operand_in,
    input wire logic [31:0] second_operand_in,
    input wire logic [31:0] dest_high_word_in,
    input wire logic [31:0] dest_low_word_in,
    input wire logic [3:0] dest_high_idx_in,
    input wire logic [3:0] dest_low_idx_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // write back to the register file
    output logic result_valid_out,
    output logic write_low_out,
    output logic write_high_out,
    output logic [31:0] dest_low_word_out,
    output logic [31:0] dest_high_word_out,
    output logic [3:0] dest_low_idx_out,
    output logic [3:0] dest_high_idx_out,
    // status
    output logic reg_fault_out,
    output logic sat_flag_out
);

    // ==========================================================
    // multipliers
    sumu_pkg::sumu_state_type s_q;
    sumu_pkg::sumu_state_type s_d;
    sumu_mul_if #(.W(sumu_pkg::HALF_W)) m0 ();
    sumu_mul_if #(.W(sumu_pkg::HALF_W)) m1 ();
    sumu_mul_if #(.W(sumu_pkg::LONG_W)) ml ();

    sumu_mul #(.W(sumu_pkg::HALF_W)) u_mul0 (.mif(m0));
    sumu_mul #(.W(sumu_pkg::HALF_W)) u_mul1 (.mif(m1));
    sumu_mul #(.W(sumu_pkg::LONG_W)) u_mul_long (.mif(ml));

    logic crossed;
    logic is_dual_add;
    logic is_long;
    logic is_signed_long;
    logic [31:0] b_sel;
    logic [15:0] half_b;
    logic signed [32:0] dual_sum;
    logic dual_ovf;
    logic [63:0] long_p;
    logic [63:0] acc_pair;
    logic status_wr;

    // ==========================================================
    // operation decode
    assign crossed = (op_in == sumu_pkg::op_dual_mul_add_crossed) ||
                     (op_in == sumu_pkg::op_dual_mul_sub_crossed);
    assign is_dual_add = (op_in == sumu_pkg::op_dual_mul_add) ||
                         (op_in == sumu_pkg::op_dual_mul_add_crossed);
    assign is_long = (op_in >= sumu_pkg::op_unsigned_long_mul) &&
                     (op_in != sumu_pkg::op_none);
    assign is_signed_long = (op_in == sumu_pkg::op_signed_long_mul) ||
                            (op_in == sumu_pkg::op_signed_long_mul_acc);
    assign status_wr = reg_wr_in && (reg_addr_in == sumu_pkg::STATUS_ADDR);
    assign acc_pair = {dest_high_word_in, dest_low_word_in};
    assign long_p = ml.p[63:0];

    // operand routing into the three multipliers
    always_comb begin
        b_sel = crossed ? {second_operand_in[15:0], second_operand_in[31:16]}
                        : second_operand_in;
        m0.a = first_operand_in[15:0];
        m0.b = b_sel[15:0];
        m1.a = first_operand_in[31:16];
        m1.b = b_sel[31:16];
        if (op_in == sumu_pkg::op_half_mul_top_bottom ||
            op_in == sumu_pkg::op_half_mul_top_top) begin
            m0.a = first_operand_in[31:16];
        end
        if (op_in == sumu_pkg::op_half_mul_bottom_top ||
            op_in == sumu_pkg::op_half_mul_top_top) begin
            m0.b = second_operand_in[31:16];
        end
        half_b = (op_in == sumu_pkg::op_word_by_top_half_mul) ?
                 second_operand_in[31:16] : second_operand_in[15:0];
        // top bit zero makes the signed long multiplier do unsigned work
        ml.a = {is_signed_long & first_operand_in[31], first_operand_in};
        ml.b = {is_signed_long & second_operand_in[31], second_operand_in};
        if (op_in == sumu_pkg::op_word_by_bottom_half_mul ||
            op_in == sumu_pkg::op_word_by_top_half_mul) begin
            ml.a = {first_operand_in[31], first_operand_in};
            ml.b = {{17{half_b[15]}}, half_b};
        end
    end

    // dual sum kept one bit wider so overflow is visible
    always_comb begin
        if (is_dual_add) begin
            dual_sum = $signed({m0.p[31], m0.p}) + $signed({m1.p[31], m1.p});
        end else begin
            dual_sum = $signed({m0.p[31], m0.p}) - $signed({m1.p[31], m1.p});
        end
        // only the final addition can overflow
        dual_ovf = is_dual_add && (dual_sum[32] != dual_sum[31]);
    end

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        s_d.wr_lo = 1'b0;
        s_d.wr_hi = 1'b0;
        s_d.fault = 1'b0;
        s_d.rdata = 32'h0;
        if (issue_valid_in && op_in != sumu_pkg::op_none) begin
            s_d.valid = 1'b1;
            s_d.wr_lo = 1'b1;
            s_d.wr_hi = is_long;
            s_d.idx_lo = dest_low_idx_in;
            s_d.idx_hi = dest_high_idx_in;
            s_d.hi = 32'h0;
            // flag a stack pointer or program counter destination
            s_d.fault = (dest_low_idx_in == sumu_pkg::STACK_POINTER_REG) ||
                        (dest_low_idx_in == sumu_pkg::PROGRAM_COUNTER_REG);
            // long forms need two distinct legal destinations
            if (is_long) begin
                s_d.fault = s_d.fault ||
                            (dest_high_idx_in == sumu_pkg::STACK_POINTER_REG) ||
                            (dest_high_idx_in == sumu_pkg::PROGRAM_COUNTER_REG) ||
                            (dest_high_idx_in == dest_low_idx_in);
            end
            case (op_in)
                sumu_pkg::op_dual_mul_add,
                sumu_pkg::op_dual_mul_add_crossed,
                sumu_pkg::op_dual_mul_sub,
                sumu_pkg::op_dual_mul_sub_crossed: begin
                    // wrapped low word is written even on overflow
                    s_d.lo = dual_sum[31:0];
                end
                sumu_pkg::op_half_mul_bottom_bottom,
                sumu_pkg::op_half_mul_bottom_top,
                sumu_pkg::op_half_mul_top_bottom,
                sumu_pkg::op_half_mul_top_top: begin
                    s_d.lo = m0.p;
                end
                sumu_pkg::op_word_by_bottom_half_mul,
                sumu_pkg::op_word_by_top_half_mul: begin
                    // upper word of the 48-bit product
                    s_d.lo = long_p[47:16];
                end
                sumu_pkg::op_unsigned_long_mul,
                sumu_pkg::op_signed_long_mul: begin
                    {s_d.hi, s_d.lo} = long_p;
                end
                sumu_pkg::op_unsigned_long_mul_acc,
                sumu_pkg::op_signed_long_mul_acc: begin
                    // two's complement sum serves both signs
                    {s_d.hi, s_d.lo} = long_p + acc_pair;
                end
                sumu_pkg::op_unsigned_long_mul_double_acc: begin
                    // cannot carry out of 64 bits
                    {s_d.hi, s_d.lo} = long_p + {32'h0, dest_high_word_in} +
                                       {32'h0, dest_low_word_in};
                end
                default: begin
                    s_d.lo = 32'h0;
                end
            endcase
        end
        // condition flags change only by a status write
        if (status_wr) begin
            s_d.nzcv = reg_wdata_in[sumu_pkg::NZCV_LSB +: 4];
            s_d.q = reg_wdata_in[sumu_pkg::SAT_BIT];
        end
        // sticky set wins over a clearing write
        if (issue_valid_in && dual_ovf) begin
            s_d.q = 1'b1;
        end
        if (reg_rd_in && reg_addr_in == sumu_pkg::STATUS_ADDR) begin
            s_d.rdata = {s_q.nzcv, s_q.q, 27'h0};
        end
    end

    // state register
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_q <= sumu_pkg::STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all from the state register
    assign reg_rdata_out = s_q.rdata;
    assign result_valid_out = s_q.valid;
    assign write_low_out = s_q.wr_lo;
    assign write_high_out = s_q.wr_hi;
    assign dest_low_word_out = s_q.lo;
    assign dest_high_word_out = s_q.hi;
    assign dest_low_idx_out = s_q.idx_lo;
    assign dest_high_idx_out = s_q.idx_hi;
    assign reg_fault_out = s_q.fault;
    assign sat_flag_out = s_q.q;

    // ==========================================================
    // checks against independent reference products
    logic [31:0] chk_bb;
    logic [31:0] chk_tt;
    logic [31:0] chk_bt;
    logic [31:0] chk_tb;
    logic [47:0] chk_wt;
    logic [63:0] chk_u;
    logic [63:0] chk_s;
    logic [32:0] chk_sum;
    logic chk_ovf;
    assign chk_bb = $signed(first_operand_in[15:0]) * $signed(second_operand_in[15:0]);
    assign chk_tt = $signed(first_operand_in[31:16]) * $signed(second_operand_in[31:16]);
    assign chk_bt = $signed(first_operand_in[15:0]) * $signed(second_operand_in[31:16]);
    assign chk_tb = $signed(first_operand_in[31:16]) * $signed(second_operand_in[15:0]);
    assign chk_wt = $signed(first_operand_in) * $signed(second_operand_in[31:16]);
    assign chk_u = first_operand_in * second_operand_in;
    assign chk_s = $signed(first_operand_in) * $signed(second_operand_in);
    assign chk_sum = (op_in == sumu_pkg::op_dual_mul_add_crossed) ?
                     {chk_bt[31], chk_bt} + {chk_tb[31], chk_tb} :
                     {chk_bb[31], chk_bb} + {chk_tt[31], chk_tt};
    assign chk_ovf = issue_valid_in && (chk_sum[32] != chk_sum[31]) &&
                     (op_in == sumu_pkg::op_dual_mul_add ||
                      op_in == sumu_pkg::op_dual_mul_add_crossed);

    property p_dual_add;
        @(posedge clock_in) disable iff (rst_in)
        $past(issue_valid_in && op_in == sumu_pkg::op_dual_mul_add) |->
            result_valid_out && dest_low_word_out == $past(chk_bb + chk_tt);
    endproperty
    a_dual_add: assert property (p_dual_add)
        else $error("dual add result wrong");

    property p_dual_sub_crossed;
        @(posedge clock_in) disable iff (rst_in)
        $past(issue_valid_in && op_in == sumu_pkg::op_dual_mul_sub_crossed) |->
            dest_low_word_out == $past(chk_bt - chk_tb);
    endproperty
    a_dual_sub_crossed: assert property (p_dual_sub_crossed)
        else $error("crossed dual subtract result wrong");

    property p_dual_sub;
        @(posedge clock_in) disable iff (rst_in)
        $past(issue_valid_in && op_in == sumu_pkg::op_dual_mul_sub) |->
            dest_low_word_out == $past(chk_bb - chk_tt) && !write_high_out;
    endproperty
    a_dual_sub: assert property (p_dual_sub)
        else $error("dual subtract result wrong");

    property p_sat_set;
        @(posedge clock_in) disable iff (rst_in)
        chk_ovf |=> sat_flag_out ##1 (sat_flag_out || $past(status_wr));
    endproperty
    a_sat_set: assert property (p_sat_set)
        else $error("saturation flag not set on overflow");

    property p_sat_hold;
        @(posedge clock_in) disable iff (rst_in)
        !chk_ovf && !status_wr |=> $stable(sat_flag_out);
    endproperty
    a_sat_hold: assert property (p_sat_hold)
        else $error("saturation flag changed without cause");

    property p_half_tb;
        @(posedge clock_in) disable iff (rst_in)
        issue_valid_in && op_in == sumu_pkg::op_half_mul_top_bottom |=>
            write_low_out && !write_high_out && dest_low_word_out == $past(chk_tb);
    endproperty
    a_half_tb: assert property (p_half_tb)
        else $error("halfword multiply result wrong");

    property p_word_top;
        @(posedge clock_in) disable iff (rst_in)
        issue_valid_in && op_in == sumu_pkg::op_word_by_top_half_mul |=>
            dest_low_word_out == $past(chk_wt[47:16]);
    endproperty
    a_word_top: assert property (p_word_top)
        else $error("word by halfword result wrong");

    property p_unsigned_long_mul;
        @(posedge clock_in) disable iff (rst_in)
        issue_valid_in && op_in == sumu_pkg::op_unsigned_long_mul |=>
            write_high_out && {dest_high_word_out, dest_low_word_out} == $past(chk_u);
    endproperty
    a_unsigned_long_mul: assert property (p_unsigned_long_mul)
        else $error("unsigned long product wrong");

    property p_unsigned_long_mul_double_acc;
        @(posedge clock_in) disable iff (rst_in)
        issue_valid_in && op_in == sumu_pkg::op_unsigned_long_mul_double_acc |=>
            {dest_high_word_out, dest_low_word_out} ==
            $past(chk_u + {32'h0, dest_high_word_in} + {32'h0, dest_low_word_in});
    endproperty
    a_unsigned_long_mul_double_acc: assert property (p_unsigned_long_mul_double_acc)
        else $error("double accumulate result wrong");

    property p_signed_long_mul_acc;
        @(posedge clock_in) disable iff (rst_in)
        issue_valid_in && op_in == sumu_pkg::op_signed_long_mul_acc |=>
            {dest_high_word_out, dest_low_word_out} == $past(chk_s + acc_pair);
    endproperty
    a_signed_long_mul_acc: assert property (p_signed_long_mul_acc)
        else $error("signed long accumulate result wrong");

    property p_flags_kept;
        @(posedge clock_in) disable iff (rst_in)
        !status_wr |=> s_q.nzcv == $past(s_q.nzcv);
    endproperty
    a_flags_kept: assert property (p_flags_kept)
        else $error("condition flags changed by a multiply");

endmodule : sumu_unit

// File: pkg/sumu_pkg.sv
// constants, operation codes and state layout of the multiply unit
package sumu_pkg;

    // ==========================================================
    // widths
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int LONG_W = 33;
    localparam int IDX_W = 4;
    localparam int ADDR_W = 4;

    // ==========================================================
    // register port map and status field layout
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h0;
    localparam int NZCV_LSB = 28;
    localparam int SAT_BIT = 27;

    // ==========================================================
    // register indices the decoder must never name
    localparam logic [IDX_W-1:0] STACK_POINTER_REG = 4'hd;
    localparam logic [IDX_W-1:0] PROGRAM_COUNTER_REG = 4'hf;

    // ==========================================================
    // operation codes
    typedef enum logic [3:0] {
        op_dual_mul_add = 4'h0,
        op_dual_mul_add_crossed = 4'h1,
        op_dual_mul_sub = 4'h2,
        op_dual_mul_sub_crossed = 4'h3,
        op_half_mul_bottom_bottom = 4'h4,
        op_half_mul_bottom_top = 4'h5,
        op_half_mul_top_bottom = 4'h6,
        op_half_mul_top_top = 4'h7,
        op_word_by_bottom_half_mul = 4'h8,
        op_word_by_top_half_mul = 4'h9,
        op_unsigned_long_mul = 4'ha,
        op_unsigned_long_mul_acc = 4'hb,
        op_unsigned_long_mul_double_acc = 4'hc,
        op_signed_long_mul = 4'hd,
        op_signed_long_mul_acc = 4'he,
        op_none = 4'hf
    } sumu_op_type;

    // ==========================================================
    // complete state of the unit
    typedef struct packed {
        logic valid;
        logic wr_lo;
        logic wr_hi;
        logic [DATA_W-1:0] lo;
        logic [DATA_W-1:0] hi;
        logic [IDX_W-1:0] idx_lo;
        logic [IDX_W-1:0] idx_hi;
        logic fault;
        logic q;
        logic [3:0] nzcv;
        logic [DATA_W-1:0] rdata;
    } sumu_state_type;

    localparam sumu_state_type STATE_RESET = '0;

endpackage : sumu_pkg

// File: pkg/sumu_mul_if.sv
// operand and product bundle between the unit and one multiplier
`timescale 1ns/1ns
interface sumu_mul_if #(parameter int W = 16);
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic [2*W-1:0] p;
    modport req (output a, output b, input p);
    modport mul (input a, input b, output p);
endinterface : sumu_mul_if

// File: src/sumu_mul.sv
// signed W by W multiplier with full width product
`timescale 1ns/1ns
module sumu_mul #(
    parameter int W = 16
) (
    // operands in, product out
    sumu_mul_if.mul mif
);

    // unsigned forms are handled by the caller with a zero top bit
    assign mif.p = $signed(mif.a) * $signed(mif.b);

endmodule : sumu_mul

// File: verif/sumu_rf_model.sv
// register file and decoder stand-in that feeds the multiply unit
`timescale 1ns/1ns
module sumu_rf_model (
    // clock
    input wire logic clock_in,
    // request from the bench
    input wire logic req_in,
    input wire sumu_pkg::sumu_op_type req_op_in,
    input wire logic [3:0] hi_sel_in,
    input wire logic [3:0] lo_sel_in,
    // issue towards the unit
    output logic issue_valid_out,
    output sumu_pkg::sumu_op_type op_out,
    output logic [31:0] first_op_out,
    output logic [31:0] second_op_out,
    output logic [31:0] hi_out,
    output logic [31:0] lo_out,
    output logic [3:0] hi_idx_out,
    output logic [3:0] lo_idx_out,
    // write back from the unit
    input wire logic wr_lo_in,
    input wire logic wr_hi_in,
    input wire logic [31:0] lo_word_in,
    input wire logic [31:0] hi_word_in,
    input wire logic [3:0] lo_idx_in,
    input wire logic [3:0] hi_idx_in
);
    logic [31:0] regs [16];

    // ==========================================================
    // issue path
    // legal register choice
    // operands live in registers 1 and 2; destinations are distinct and avoid
    // 13 and 15 unless the bench provokes the fault flag on purpose
    assign issue_valid_out = req_in;
    assign op_out = req_op_in;
    assign first_op_out = regs[1];
    assign second_op_out = regs[2];
    assign hi_out = regs[hi_sel_in];
    assign lo_out = regs[lo_sel_in];
    assign hi_idx_out = hi_sel_in;
    assign lo_idx_out = lo_sel_in;

    // ==========================================================
    // write back lands one edge after the result shows
    always @(posedge clock_in) begin
        if (wr_lo_in) regs[lo_idx_in] <= lo_word_in;
        if (wr_hi_in) regs[hi_idx_in] <= hi_word_in;
    end
endmodule : sumu_rf_model

// File: verif/signed_unsigned_multiply_unit_tb.sv
// self-checking bench for the multiply unit
`timescale 1ns/1ns
module signed_unsigned_multiply_unit_tb;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic req = 1'b0;
    sumu_pkg::sumu_op_type req_op = sumu_pkg::op_none;
    logic [3:0] hs_q = 4'h3, ls_q = 4'h4, reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic iv, rv, wl, wh, flt, sat;
    sumu_pkg::sumu_op_type opw;
    logic [31:0] fop, sop, hw, lw, rdata, dlo, dhi;
    logic [3:0] hi_i, li_i, dli, dhi_i;
    int err_count = 0, checks_done = 0, cycles = 0;
    logic [74:0] exp_q [$];
    logic sat_e = 1'b0;
    logic [3:0] nzcv_e = 4'h0;

    sumu_rf_model rf (.clock_in(clock_in), .req_in(req), .req_op_in(req_op),
        .hi_sel_in(hs_q), .lo_sel_in(ls_q), .issue_valid_out(iv), .op_out(opw),
        .first_op_out(fop), .second_op_out(sop), .hi_out(hw), .lo_out(lw), .hi_idx_out(hi_i),
        .lo_idx_out(li_i), .wr_lo_in(wl), .wr_hi_in(wh), .lo_word_in(dlo),
        .hi_word_in(dhi), .lo_idx_in(dli), .hi_idx_in(dhi_i));

    sumu_unit dut (.clock_in(clock_in), .rst_in(rst_in), .issue_valid_in(iv), .op_in(opw),
        .first_operand_in(fop), .second_operand_in(sop), .dest_high_word_in(hw),
        .dest_low_word_in(lw), .dest_high_idx_in(hi_i), .dest_low_idx_in(li_i),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .result_valid_out(rv),
        .write_low_out(wl), .write_high_out(wh), .dest_low_word_out(dlo),
        .dest_high_word_out(dhi), .dest_low_idx_out(dli), .dest_high_idx_out(dhi_i),
        .reg_fault_out(flt), .sat_flag_out(sat));

    // ==========================================================
    // clock and hang guard
    initial begin
        forever #2 clock_in = ~clock_in;
    end

    // the ceiling is about forty times the length of the whole sequence
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end

    // ==========================================================
    // reference arithmetic, all in 64-bit two's complement
    function automatic logic [63:0] sx(input logic [15:0] v);
        return {{48{v[15]}}, v};
    endfunction : sx

    function automatic logic [63:0] calc(input logic [3:0] op, input logic [31:0] a, b, h, l,
                                         output logic s);
        logic [31:0] c;
        logic [63:0] p0, p1, r, sa, sb;
        c = (op < 4'h4 && op[0]) ? {b[15:0], b[31:16]} : b;
        p0 = sx(a[15:0]) * sx(c[15:0]);
        p1 = sx(a[31:16]) * sx(c[31:16]);
        sa = {{32{a[31]}}, a};
        sb = {{32{b[31]}}, b};
        s = 1'b0;
        case (op)
            4'h0, 4'h1: begin
                r = p0 + p1;
                s = r[32] ^ r[31];
            end
            4'h2, 4'h3: r = p0 - p1;
            4'h4, 4'h5, 4'h6, 4'h7: begin
                r = sx(op[1] ? a[31:16] : a[15:0]) * sx(op[0] ? b[31:16] : b[15:0]);
            end
            4'h8, 4'h9: r = (sa * sx(op[0] ? b[31:16] : b[15:0])) >> 16;
            4'ha: r = {32'h0, a} * {32'h0, b};
            4'hb: r = {32'h0, a} * {32'h0, b} + {h, l};
            4'hc: r = {32'h0, a} * {32'h0, b} + h + l;
            4'hd: r = sa * sb;
            4'he: r = sa * sb + {h, l};
            default: r = 64'h0;
        endcase
        return (op < 4'ha) ? {32'h0, r[31:0]} : r;
    endfunction : calc

    // ==========================================================
    // compares and closing report
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_res(input logic [74:0] got, input logic [74:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_res

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // results are judged at the falling edge, clear of the launching edge
    always @(negedge clock_in) begin
        if (rv === 1'b1) begin
            if (exp_q.size() == 0) chk_word(32'h1, 32'h0);
            else chk_res({flt, wh, wl, dhi_i, dli, dhi, dlo}, exp_q.pop_front());
        end
    end

    // ==========================================================
    // access tasks
    task automatic op_go(input sumu_pkg::sumu_op_type op, input logic [31:0] a, b, h, l,
                         input logic [3:0] hs, ls);
        logic [63:0] r;
        logic s, lg, f;
        r = calc(op, a, b, h, l, s);
        lg = op inside {[4'ha:4'he]};
        f = ls inside {sumu_pkg::STACK_POINTER_REG, sumu_pkg::PROGRAM_COUNTER_REG}
            || (lg && (hs == ls || hs inside {4'hd, 4'hf}));
        if (op != sumu_pkg::op_none) exp_q.push_back({f, lg, 1'b1, hs, ls, r});
        sat_e = sat_e | s;
        @(posedge clock_in);
        rf.regs[1] <= a;
        rf.regs[2] <= b;
        rf.regs[hs] <= h;
        rf.regs[ls] <= l;
        req <= 1'b1;
        req_op <= op;
        hs_q <= hs;
        ls_q <= ls;
    endtask : op_go

    // two idle edges let the last write back land before registers reload
    task automatic op_end();
        @(posedge clock_in);
        req <= 1'b0;
        repeat (2) @(posedge clock_in);
    endtask : op_end

    // back-to-back ops, each on its own destination pair
    task automatic burst(input int first, n, input logic [31:0] a, b, h, l);
        for (int i = 0; i < n; i++) begin
            op_go(sumu_pkg::sumu_op_type'(first + i), a, b, h, l, 4'(3 + 2 * i), 4'(4 + 2 * i));
        end
        op_end();
    endtask : burst

    task automatic rd(input logic [3:0] ad, input logic [31:0] exp);
        @(posedge clock_in);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clock_in);
        reg_rd <= 1'b0;
        @(negedge clock_in);
        chk_word(rdata, exp);
        chk_word(32'(sat), 32'(sat_e));
    endtask : rd

    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clock_in);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clock_in);
        reg_wr <= 1'b0;
        if (ad == sumu_pkg::STATUS_ADDR) begin
            nzcv_e = d[31:28];
            sat_e = d[27];
        end
    endtask : wr

    // ==========================================================
    // main sequence
    initial begin
        logic [63:0] r;
        logic s;
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(4'h0, 32'h0);
        $display("reset test done");
        burst(0, 4, 32'h0003fffe, 32'h00020005, 32'h0, 32'h0);
        rd(4'h0, {nzcv_e, sat_e, 27'h0});
        burst(0, 4, 32'h80008000, 32'h80008000, 32'h0, 32'h0);
        rd(4'h0, {nzcv_e, sat_e, 27'h0});
        burst(2, 1, 32'h12345678, 32'h9abcdef0, 32'h0, 32'h0);
        rd(4'h0, {nzcv_e, sat_e, 27'h0});
        wr(4'h0, 32'h0);
        rd(4'h0, {nzcv_e, sat_e, 27'h0});
        $display("dual test done");
        burst(4, 4, 32'h80000007, 32'h0003fffb, 32'h0, 32'h0);
        burst(8, 2, 32'h80000001, 32'h7fff8000, 32'h0, 32'h0);
        $display("halfword test done");
        wr(4'h0, 32'ha0000000);
        burst(10, 5, 32'hfffffffe, 32'h80000003,
              32'h80000001, 32'hffffffff);
        rd(4'h0, {nzcv_e, sat_e, 27'h0});
        r = calc(4'he, 32'hfffffffe, 32'h80000003, 32'h80000001, 32'hffffffff, s);
        chk_word(rf.regs[12], r[31:0]);
        chk_word(rf.regs[11], r[63:32]);
        $display("long test done");
        op_go(sumu_pkg::op_half_mul_top_top, 32'h1, 32'h2, 32'h0, 32'h0, 4'h3, 4'hd);
        op_go(sumu_pkg::op_signed_long_mul, 32'h1, 32'h2, 32'h0, 32'h0, 4'h5, 4'h5);
        op_go(sumu_pkg::op_unsigned_long_mul, 32'h1, 32'h2, 32'h0, 32'h0, 4'hf, 4'h6);
        op_go(sumu_pkg::op_none, 32'h1, 32'h2, 32'h0, 32'h0, 4'h3, 4'h4);
        op_end();
        wr(4'h5, 32'hffffffff);
        rd(4'h5, 32'h0);
        rd(4'h0, {nzcv_e, sat_e, 27'h0});
        chk_word(32'(exp_q.size()), 32'h0);
        $display("fault and port test done");
        wrap_up();
    end
endmodule : signed_unsigned_multiply_unit_tb
